// ===== hw/mqf_pkg.sv
// Shared constants for the multi-queue FIFO core and its host end
package mqf_pkg;
  localparam int QMAX = 4;
  localparam int QSEL_W = 2;
  localparam int DEV_W = 3;
  localparam int SEL_W = DEV_W + QSEL_W;
  localparam int EXP_MAX = 8;
  localparam int DW = 18;
  localparam int HW = 9;
  localparam int WORDS_PER_BLOCK = 512;
  localparam int UNITS_PER_BLOCK = 1024;
  localparam int POOL_BLOCKS_DEF = 64;
  localparam int BLK_W = 9;
  localparam int THR_W = 16;
  localparam int NQ_W = 3;
  localparam int CFG_NQ_LSB = 0;
  localparam int CFG_NQ_W = 2;
  localparam int CFG_Q_LSB = CFG_NQ_LSB + CFG_NQ_W;
  localparam int CFG_BLK_OFS = 0;
  localparam int CFG_PAF_OFS = CFG_BLK_OFS + BLK_W;
  localparam int CFG_PAE_OFS = CFG_PAF_OFS + THR_W;
  localparam int CFG_Q_BITS = BLK_W + 2 * THR_W;
  localparam int CFG_BITS = CFG_Q_LSB + QMAX * CFG_Q_BITS;
  localparam int SER_CNT_W = 8;
  localparam logic [THR_W-1:0] PAF_THR_DEF = 16'h0010;
  localparam logic [THR_W-1:0] PAE_THR_DEF = 16'h0010;
  localparam logic [NQ_W-1:0] NQ_DEF = 3'h4;
  localparam logic [1:0] NEED_NARROW = 2'h1;
  localparam logic [1:0] NEED_WIDE = 2'h2;
  localparam int MR_CYCLES = 4;
  localparam int FIFO_DEPTH = 16;
endpackage : mqf_pkg

// ===== hw/mqf_link_if.sv
// Link between the multi-queue core and its host
`timescale 1ns/10ps
interface mqf_link_if import mqf_pkg::*; ();
  logic [DW-1:0] din;
  logic write_en;
  logic [SEL_W-1:0] write_queue_select;
  logic full_flag;
  logic almost_full_selected;
  logic [QMAX-1:0] almost_full_status_bus;
  logic [DW-1:0] dout;
  logic dout_oe;
  logic read_en;
  logic [SEL_W-1:0] read_queue_select;
  logic output_valid;
  logic almost_empty_selected;
  logic [QMAX-1:0] almost_empty_status_bus;
  logic master_reset_n;
  logic partial_reset_n;
  logic in_wide;
  logic out_wide;
  logic serial_en;
  logic serial_data;
  modport dev(
    input din, write_en, write_queue_select, read_en, read_queue_select,
    input master_reset_n, partial_reset_n, in_wide, out_wide, serial_en, serial_data,
    output full_flag, almost_full_selected, almost_full_status_bus,
    output dout, dout_oe, output_valid, almost_empty_selected, almost_empty_status_bus
  );
  modport host(
    output din, write_en, write_queue_select, read_en, read_queue_select,
    output master_reset_n, partial_reset_n, in_wide, out_wide, serial_en, serial_data,
    input full_flag, almost_full_selected, almost_full_status_bus,
    input dout, dout_oe, output_valid, almost_empty_selected, almost_empty_status_bus
  );
endinterface : mqf_link_if

// ===== hw/mqf_device.sv
// Multi-queue FIFO core: shared block memory, per-queue pointers, flags, serial setup
`timescale 1ns/10ps
module mqf_device import mqf_pkg::*; #(
  parameter int POOL_BLOCKS = POOL_BLOCKS_DEF,
  parameter logic [DEV_W-1:0] DEVICE_INDEX = 3'h0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link to host
  mqf_link_if.dev link
);
  localparam int UNITS = POOL_BLOCKS * UNITS_PER_BLOCK;
  localparam int AW = $clog2(UNITS);
  localparam int CW = AW + 2;
  localparam int WORDS = POOL_BLOCKS * WORDS_PER_BLOCK;

  // Memory kept as two 9-bit halves so a block reads as 512x18 or 1024x9
  logic [HW-1:0] mem_lo [WORDS];
  logic [HW-1:0] mem_hi [WORDS];

  logic in_wide_r, out_wide_r, prog_ok_r;
  logic [NQ_W-1:0] nq_r;
  logic [BLK_W-1:0] blk_r [QMAX];
  logic [THR_W-1:0] paf_thr_r [QMAX];
  logic [THR_W-1:0] pae_thr_r [QMAX];
  logic [AW-1:0] wptr_r [QMAX];
  logic [AW-1:0] rptr_r [QMAX];
  logic [CW-1:0] cnt_r [QMAX];
  logic [CW-1:0] cnt_nxt [QMAX];
  logic [AW-1:0] base [QMAX];
  logic [CW-1:0] size [QMAX];
  logic [CFG_BITS-1:0] ser_sr_r;
  logic [SER_CNT_W-1:0] ser_cnt_r;
  logic ser_en_d_r;
  logic [DW-1:0] dout_r;
  logic ov_r, oe_r;
  logic [SEL_W-1:0] out_sel_r;
  logic full_r, paf_sel_r, pae_sel_r;
  logic [QMAX-1:0] paf_bus_r, pae_bus_r;

  logic [QSEL_W-1:0] wq, rq;
  logic w_act, r_act, w_ok, take, pr_hit, cfg_apply, mr_act;
  logic [1:0] w_need, r_need;
  logic [AW-1:0] w_addr, r_adv, head;
  logic [CW-1:0] cnt_after, cfg_total;
  logic [DW-1:0] head_data;

  function automatic logic [CW-1:0] q_size(input logic [BLK_W-1:0] b);
    return CW'(b) * CW'(UNITS_PER_BLOCK);
  endfunction : q_size

  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p, input logic [1:0] n,
                                              input logic [CW-1:0] s);
    logic [CW-1:0] t;
    t = CW'(p) + CW'(n);
    return (t >= s) ? '0 : t[AW-1:0];
  endfunction : ptr_step

  function automatic logic q_active(input logic [SEL_W-1:0] sel, input logic [NQ_W-1:0] nq);
    return (sel[SEL_W-1:QSEL_W] == DEVICE_INDEX) &&
           (NQ_W'(sel[QSEL_W-1:0]) < nq);
  endfunction : q_active

  always_comb begin
    logic [CW-1:0] acc;
    logic [CW-1:0] tot;
    acc = '0;
    tot = '0;
    for (int i = 0; i < QMAX; i++) begin
      base[i] = acc[AW-1:0];
      size[i] = q_size(blk_r[i]);
      acc = acc + size[i];
      tot = tot + CW'(ser_sr_r[CFG_Q_LSB + i * CFG_Q_BITS + CFG_BLK_OFS +: BLK_W]);
    end
    cfg_total = tot;
  end

  assign mr_act = !link.master_reset_n;
  assign wq = link.write_queue_select[QSEL_W-1:0];
  assign rq = link.read_queue_select[QSEL_W-1:0];
  assign w_act = q_active(link.write_queue_select, nq_r);
  assign r_act = q_active(link.read_queue_select, nq_r);
  assign w_need = in_wide_r ? NEED_WIDE : NEED_NARROW;
  assign r_need = out_wide_r ? NEED_WIDE : NEED_NARROW;
  assign pr_hit = !link.partial_reset_n && w_act &&
                  (link.write_queue_select == link.read_queue_select);
  assign w_ok = link.write_en && w_act && !mr_act && !pr_hit &&
                (size[wq] - cnt_r[wq] >= CW'(w_need));
  assign take = link.read_en && ov_r && r_act && !mr_act && !pr_hit &&
                (out_sel_r == link.read_queue_select);
  assign w_addr = base[wq] + wptr_r[wq];
  assign r_adv = take ? ptr_step(rptr_r[rq], r_need, size[rq]) : rptr_r[rq];
  assign head = base[rq] + r_adv;
  assign cnt_after = cnt_r[rq] - (take ? CW'(r_need) : '0);
  // Low half is the earlier unit in both directions
  assign head_data = out_wide_r ? {mem_hi[head[AW-1:1]], mem_lo[head[AW-1:1]]} :
                     {{(DW-HW){1'b0}}, head[0] ? mem_hi[head[AW-1:1]] :
                     mem_lo[head[AW-1:1]]};
  assign cfg_apply = ser_en_d_r && !link.serial_en && prog_ok_r &&
                     (ser_cnt_r == SER_CNT_W'(CFG_BITS)) &&
                     (cfg_total <= CW'(POOL_BLOCKS));

  always_comb begin
    for (int i = 0; i < QMAX; i++) begin
      cnt_nxt[i] = cnt_r[i] + ((w_ok && wq == QSEL_W'(i)) ? CW'(w_need) : '0)
                   - ((take && rq == QSEL_W'(i)) ? CW'(r_need) : '0);
    end
  end

  // Data store
  always_ff @(posedge clock) begin
    if (w_ok) begin
      if (in_wide_r) begin
        mem_lo[w_addr[AW-1:1]] <= link.din[HW-1:0];
        mem_hi[w_addr[AW-1:1]] <= link.din[DW-1:HW];
      end else if (w_addr[0]) begin
        mem_hi[w_addr[AW-1:1]] <= link.din[HW-1:0];
      end else begin
        mem_lo[w_addr[AW-1:1]] <= link.din[HW-1:0];
      end
    end
  end

  // Pointers and fill counts
  always_ff @(posedge clock) begin
    if (rst || mr_act || cfg_apply) begin
      for (int i = 0; i < QMAX; i++) begin
        wptr_r[i] <= '0;
        rptr_r[i] <= '0;
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < QMAX; i++) begin
        cnt_r[i] <= cnt_nxt[i];
      end
      if (w_ok) begin
        wptr_r[wq] <= ptr_step(wptr_r[wq], w_need, size[wq]);
      end
      if (take) begin
        rptr_r[rq] <= r_adv;
      end
      if (pr_hit) begin
        wptr_r[wq] <= '0;
        rptr_r[wq] <= '0;
        cnt_r[wq] <= '0;
      end
    end
  end

  // Configuration: straps, defaults, serial load
  always_ff @(posedge clock) begin
    if (rst || mr_act) begin
      in_wide_r <= rst ? 1'b1 : link.in_wide;
      out_wide_r <= rst ? 1'b1 : link.out_wide;
      prog_ok_r <= !rst;
      nq_r <= NQ_DEF;
      for (int i = 0; i < QMAX; i++) begin
        blk_r[i] <= BLK_W'(POOL_BLOCKS / QMAX);
        paf_thr_r[i] <= PAF_THR_DEF;
        pae_thr_r[i] <= PAE_THR_DEF;
      end
    end else if (cfg_apply) begin
      nq_r <= NQ_W'(ser_sr_r[CFG_NQ_LSB +: CFG_NQ_W]) + NQ_W'(1);
      for (int i = 0; i < QMAX; i++) begin
        blk_r[i] <= ser_sr_r[CFG_Q_LSB + i * CFG_Q_BITS + CFG_BLK_OFS +: BLK_W];
        paf_thr_r[i] <= ser_sr_r[CFG_Q_LSB + i * CFG_Q_BITS + CFG_PAF_OFS +: THR_W];
        pae_thr_r[i] <= ser_sr_r[CFG_Q_LSB + i * CFG_Q_BITS + CFG_PAE_OFS +: THR_W];
      end
    end
  end

  // Serial shifter, LSB first, length-checked on the falling enable
  always_ff @(posedge clock) begin
    if (rst || mr_act) begin
      ser_sr_r <= '0;
      ser_cnt_r <= '0;
      ser_en_d_r <= 1'b0;
    end else begin
      ser_en_d_r <= link.serial_en;
      if (link.serial_en) begin
        ser_sr_r <= {link.serial_data, ser_sr_r[CFG_BITS-1:1]};
        if (ser_cnt_r != '1) begin
          ser_cnt_r <= ser_cnt_r + SER_CNT_W'(1);
        end
      end else if (ser_en_d_r) begin
        ser_cnt_r <= '0;
      end
    end
  end

  // Fall-through output register
  always_ff @(posedge clock) begin
    if (rst) begin
      dout_r <= '0;
      ov_r <= 1'b0;
      oe_r <= 1'b0;
      out_sel_r <= '0;
    end else begin
      out_sel_r <= link.read_queue_select;
      oe_r <= link.read_queue_select[SEL_W-1:QSEL_W] == DEVICE_INDEX;
      if (!r_act || mr_act || pr_hit || cfg_apply) begin
        ov_r <= 1'b0;
      end else if (cnt_after >= CW'(r_need)) begin
        dout_r <= head_data;
        ov_r <= 1'b1;
      end else begin
        ov_r <= 1'b0;
      end
    end
  end

  // Flags, computed from the post-update fill so back-to-back traffic stays exact
  always_ff @(posedge clock) begin
    if (rst || mr_act) begin
      full_r <= 1'b1;
      paf_sel_r <= 1'b0;
      pae_sel_r <= 1'b0;
      paf_bus_r <= '0;
      pae_bus_r <= '0;
    end else begin
      full_r <= !w_act || (size[wq] - cnt_nxt[wq] < CW'(w_need));
      paf_sel_r <= w_act && (size[wq] - cnt_nxt[wq] <= CW'(paf_thr_r[wq]));
      pae_sel_r <= r_act && (cnt_nxt[rq] <= CW'(pae_thr_r[rq]));
      for (int i = 0; i < QMAX; i++) begin
        paf_bus_r[i] <= (NQ_W'(i) < nq_r) &&
                        (size[i] - cnt_nxt[i] <= CW'(paf_thr_r[i]));
        pae_bus_r[i] <= (NQ_W'(i) < nq_r) && (cnt_nxt[i] <= CW'(pae_thr_r[i]));
      end
    end
  end

  assign link.dout = dout_r;
  assign link.dout_oe = oe_r;
  assign link.output_valid = ov_r;
  assign link.full_flag = full_r;
  assign link.almost_full_selected = paf_sel_r;
  assign link.almost_empty_selected = pae_sel_r;
  assign link.almost_full_status_bus = paf_bus_r;
  assign link.almost_empty_status_bus = pae_bus_r;
endmodule : mqf_device

// ===== hw/mqf_host.sv
// Host end: write staging FIFO, queue selection, resets, serial setup sender
`timescale 1ns/10ps
module mqf_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CNW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r, rp_r;
  logic [CNW-1:0] cnt_r, cnt_nxt;
  logic ready_r;
  logic push, pop;

  assign push = in_valid && ready_r;
  assign pop = out_ready && (cnt_r != '0);
  assign cnt_nxt = cnt_r + (push ? CNW'(1) : '0) - (pop ? CNW'(1) : '0);

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ready_r <= 1'b1;
    end else begin
      wp_r <= push ? ((wp_r == PW'(DEPTH - 1)) ? '0 : wp_r + PW'(1)) : wp_r;
      rp_r <= pop ? ((rp_r == PW'(DEPTH - 1)) ? '0 : rp_r + PW'(1)) : rp_r;
      cnt_r <= cnt_nxt;
      ready_r <= cnt_nxt != CNW'(DEPTH);
    end
  end

  assign in_ready = ready_r;
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
endmodule : mqf_fifo

module mqf_host import mqf_pkg::*; #(
  parameter int STAGE_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write request
  input wire logic push_valid,
  input wire logic [SEL_W-1:0] push_queue,
  input wire logic [DW-1:0] push_data,
  output logic push_ready,
  // Read request
  input wire logic [SEL_W-1:0] pop_queue,
  input wire logic pop_enable,
  output logic [DW-1:0] pop_data,
  output logic pop_valid,
  // Setup and resets
  input wire logic in_wide_sel,
  input wire logic out_wide_sel,
  input wire logic mr_req,
  input wire logic pr_req,
  input wire logic cfg_start,
  input wire logic [CFG_BITS-1:0] cfg_word,
  // Link to core
  mqf_link_if.host link
);
  localparam int MRC_W = $clog2(MR_CYCLES + 1);
  localparam int SC_W = $clog2(CFG_BITS + 1);
  logic f_valid, issue;
  logic [SEL_W+DW-1:0] f_data;
  logic [SEL_W-1:0] wsel_r, rsel_r;
  logic [1:0] age_r;
  logic we_r, re_r, pr_pend_r, prn_r, mrn_r, ser_en_r, ser_d_r;
  logic [DW-1:0] din_r, pop_data_r;
  logic pop_valid_r;
  logic [MRC_W-1:0] mr_cnt_r;
  logic [SC_W-1:0] ser_cnt_r;
  logic [CFG_BITS-1:0] ser_sh_r;

  mqf_fifo #(.W(SEL_W + DW), .DEPTH(STAGE_DEPTH)) u_stage (
    .clock(clock),
    .rst(rst),
    .in_valid(push_valid),
    .in_data({push_queue, push_data}),
    .in_ready(push_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(issue)
  );

  // Full flag lags a select change, so wait two cycles and write every other cycle
  assign issue = f_valid && !we_r && mrn_r && prn_r && !pr_pend_r && (age_r == 2'h2) &&
                 (wsel_r == f_data[SEL_W+DW-1:DW]) && !link.full_flag;

  always_ff @(posedge clock) begin
    if (rst) begin
      wsel_r <= '0;
      age_r <= 2'h0;
      we_r <= 1'b0;
      din_r <= '0;
    end else begin
      we_r <= issue;
      din_r <= issue ? f_data[DW-1:0] : din_r;
      if (f_valid && !pr_pend_r && prn_r && f_data[SEL_W+DW-1:DW] != wsel_r) begin
        wsel_r <= f_data[SEL_W+DW-1:DW];
        age_r <= 2'h0;
      end else if (age_r != 2'h2) begin
        age_r <= age_r + 2'h1;
      end
    end
  end

  // Read side: one word taken per two cycles, captured on the accepting edge
  always_ff @(posedge clock) begin
    if (rst) begin
      rsel_r <= '0;
      re_r <= 1'b0;
      pop_data_r <= '0;
      pop_valid_r <= 1'b0;
    end else begin
      rsel_r <= (pr_pend_r || pr_req) ? wsel_r : pop_queue;
      re_r <= link.output_valid && !re_r && pop_enable && !pr_pend_r && !pr_req &&
              (rsel_r == pop_queue);
      pop_valid_r <= re_r && link.output_valid;
      if (re_r && link.output_valid) begin
        pop_data_r <= link.dout;
      end
    end
  end

  // Resets: master reset after own reset and on request, partial after aligning selects
  always_ff @(posedge clock) begin
    if (rst) begin
      mr_cnt_r <= MRC_W'(MR_CYCLES);
      mrn_r <= 1'b0;
      pr_pend_r <= 1'b0;
      prn_r <= 1'b1;
    end else begin
      if (mr_req) begin
        mr_cnt_r <= MRC_W'(MR_CYCLES);
      end else if (mr_cnt_r != '0) begin
        mr_cnt_r <= mr_cnt_r - MRC_W'(1);
      end
      mrn_r <= !mr_req && (mr_cnt_r == '0);
      prn_r <= !pr_pend_r;
      pr_pend_r <= pr_req && !pr_pend_r && prn_r;
    end
  end

  // Serial setup sender, LSB first, only after master reset has finished
  always_ff @(posedge clock) begin
    if (rst || !mrn_r) begin
      ser_cnt_r <= '0;
      ser_sh_r <= '0;
      ser_en_r <= 1'b0;
      ser_d_r <= 1'b0;
    end else if (ser_cnt_r != '0) begin
      ser_en_r <= 1'b1;
      ser_d_r <= ser_sh_r[0];
      ser_sh_r <= {1'b0, ser_sh_r[CFG_BITS-1:1]};
      ser_cnt_r <= ser_cnt_r - SC_W'(1);
    end else begin
      ser_en_r <= 1'b0;
      if (cfg_start && !ser_en_r) begin
        ser_sh_r <= cfg_word;
        ser_cnt_r <= SC_W'(CFG_BITS);
      end
    end
  end

  assign link.din = din_r;
  assign link.write_en = we_r;
  assign link.write_queue_select = wsel_r;
  assign link.read_en = re_r;
  assign link.read_queue_select = rsel_r;
  assign link.master_reset_n = mrn_r;
  assign link.partial_reset_n = prn_r;
  assign link.in_wide = in_wide_sel;
  assign link.out_wide = out_wide_sel;
  assign link.serial_en = ser_en_r;
  assign link.serial_data = ser_d_r;
  assign pop_data = pop_data_r;
  assign pop_valid = pop_valid_r;
endmodule : mqf_host

// ===== verification/mqf_link_chk.sv
// Link assertions between the multi-queue core and its host end
`timescale 1ns/10ps
module mqf_link_chk import mqf_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write side
  input wire logic write_en,
  input wire logic [SEL_W-1:0] write_queue_select,
  input wire logic full_flag,
  // Read side
  input wire logic [DW-1:0] dout,
  input wire logic dout_oe,
  input wire logic read_en,
  input wire logic [SEL_W-1:0] read_queue_select,
  input wire logic output_valid,
  // Setup and resets
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic out_wide
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Selects agree while the pulse is low, and it lasts one cycle
  sequence pr_window_s;
    (write_queue_select == read_queue_select) ##1 partial_reset_n;
  endsequence

  // Nothing valid and no reset of either kind
  sequence quiet_s;
    !output_valid && master_reset_n && partial_reset_n;
  endsequence

  a_write_not_full: assert property (write_en |-> !full_flag)
    else $error("write strobe while full");
  a_write_spaced: assert property (write_en |=> !write_en)
    else $error("write strobes back to back");
  a_master_clears: assert property (!master_reset_n |=> full_flag && !output_valid)
    else $error("master reset left flags set");
  a_partial_pulse: assert property ($fell(partial_reset_n) |-> pr_window_s)
    else $error("partial reset pulse malformed");
  a_partial_drops_valid: assert property (
    !partial_reset_n && master_reset_n |=> !output_valid)
    else $error("valid survived partial reset");
  a_select_enables: assert property (
    $stable(read_queue_select) && read_queue_select[SEL_W-1:QSEL_W] == 3'h0 |=> dout_oe)
    else $error("output enable missing for own device");
  a_empty_holds_word: assert property (quiet_s ##1 quiet_s |-> $stable(dout))
    else $error("output word changed while not valid");
  a_narrow_upper_zero: assert property (
    master_reset_n && !out_wide && $stable(out_wide) && output_valid |-> dout[DW-1:HW] == 9'h0)
    else $error("upper half driven in narrow output");
  a_valid_holds: assert property (
    output_valid && !read_en && $stable(read_queue_select) && master_reset_n
      && partial_reset_n |=> output_valid && $stable(dout))
    else $error("head word lost without a read");
endmodule : mqf_link_chk

// ===== verification/testbench.sv
// Self-checking bench: core and host joined by the link, staging FIFO reached through the host
`timescale 1ns/10ps
module testbench import mqf_pkg::*; ();
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic push_valid, push_ready, pop_enable, pop_valid, in_wide_sel, out_wide_sel, ok;
  logic mr_req, pr_req, cfg_start;
  logic [SEL_W-1:0] push_queue, pop_queue;
  logic [DW-1:0] push_data, pop_data, d, e, g;
  logic [CFG_BITS-1:0] cfg_word;
  logic [31:0] seed = 32'h2bdd;
  logic [8:0] units[$];
  logic [DW-1:0] fq[$];
  logic [DW-1:0] model[QMAX][$];
  int n_mismatch = 0;
  int cmp_count = 0;

  always #5 clock = ~clock;

  mqf_link_if link ();
  mqf_device #(.POOL_BLOCKS(4), .DEVICE_INDEX(3'h0)) i_mqf_device (
    .clock(clock), .rst(rst), .link(link));
  mqf_host #(.STAGE_DEPTH(FIFO_DEPTH)) i_mqf_host (
    .clock(clock), .rst(rst), .push_valid(push_valid), .push_queue(push_queue),
    .push_data(push_data), .push_ready(push_ready), .pop_queue(pop_queue),
    .pop_enable(pop_enable), .pop_data(pop_data), .pop_valid(pop_valid),
    .in_wide_sel(in_wide_sel), .out_wide_sel(out_wide_sel), .mr_req(mr_req),
    .pr_req(pr_req), .cfg_start(cfg_start), .cfg_word(cfg_word), .link(link));
  mqf_link_chk i_mqf_link_chk (
    .clock(clock), .rst(rst), .write_en(link.write_en),
    .write_queue_select(link.write_queue_select), .full_flag(link.full_flag),
    .dout(link.dout), .dout_oe(link.dout_oe), .read_en(link.read_en),
    .read_queue_select(link.read_queue_select), .output_valid(link.output_valid),
    .master_reset_n(link.master_reset_n), .partial_reset_n(link.partial_reset_n),
    .out_wide(link.out_wide));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr_next

  task automatic get_rand(output logic [DW-1:0] v);
    seed = lfsr_next(seed);
    v = seed[DW-1:0];
  endtask : get_rand

  // Frame with equal blocks and default thresholds for the first nq queues
  function automatic logic [CFG_BITS-1:0] make_cfg(input int nq, input logic [BLK_W-1:0] blk);
    logic [CFG_BITS-1:0] w;
    w = '0;
    w[CFG_NQ_LSB +: CFG_NQ_W] = CFG_NQ_W'(nq - 1);
    for (int i = 0; i < nq; i++) begin
      w[CFG_Q_LSB + CFG_Q_BITS * i + CFG_BLK_OFS +: BLK_W] = blk;
      w[CFG_Q_LSB + CFG_Q_BITS * i + CFG_PAF_OFS +: THR_W] = PAF_THR_DEF;
      w[CFG_Q_LSB + CFG_Q_BITS * i + CFG_PAE_OFS +: THR_W] = PAE_THR_DEF;
    end
    return w;
  endfunction : make_cfg

  task automatic chk_word(input string name, input logic [DW-1:0] x, input logic [DW-1:0] y);
    cmp_count++;
    if (y !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, x, y);
    end
  endtask : chk_word

  task automatic chk_bits(input string name, input logic [3:0] x, input logic [3:0] y);
    cmp_count++;
    if (y !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, x, y);
    end
  endtask : chk_bits

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask : cycles

  task automatic push(input logic [SEL_W-1:0] q, input logic [DW-1:0] v);
    int t;
    t = 0;
    {push_valid, push_queue, push_data} = {1'b1, q, v};
    while (push_ready !== 1'b1) begin
      @(negedge clock);
      t++;
      if (t == 200) begin
        n_mismatch++;
        $display("[FAIL] push_ready expected 1 seen %b", push_ready);
        finish_test();
      end
    end
    @(negedge clock);
    push_valid = 1'b0;
    @(negedge clock);
  endtask : push

  // Waits a bounded time for one word; got is low if none came
  task automatic pop(input logic [SEL_W-1:0] q, output logic [DW-1:0] v, output logic got,
                     input logic need = 1'b1);
    int t;
    t = 0;
    {pop_queue, pop_enable} = {q, 1'b1};
    while (pop_valid !== 1'b1 && t < 60) begin
      @(negedge clock);
      t++;
    end
    got = (pop_valid === 1'b1);
    if (!got && need) begin
      n_mismatch++;
      $display("[FAIL] pop_valid expected 1 seen %b", pop_valid);
      finish_test();
    end
    v = pop_data;
    pop_enable = 1'b0;
    @(negedge clock);
  endtask : pop

  task automatic mreset;
    mr_req = 1'b1;
    @(negedge clock);
    mr_req = 1'b0;
    cycles(15);
  endtask : mreset

  initial begin
    {push_valid, pop_enable, mr_req, pr_req, cfg_start} = '0;
    {in_wide_sel, out_wide_sel} = 2'h3;
    {push_queue, pop_queue, push_data, cfg_word} = '0;
    cycles(3);
    rst = 1'b0;
    cycles(12);
    chk_bits("almost empty bus", 4'hf, link.almost_empty_status_bus);
    chk_bits("almost full bus", 4'h0, link.almost_full_status_bus);
    for (int i = 0; i < 12; i++) begin
      get_rand(d);
      push({3'h0, d[1:0]}, d);
      model[d[1:0]].push_back(d);
    end
    for (int q = 0; q < QMAX; q++) begin
      while (model[q].size() > 0) begin
        pop({3'h0, 2'(q)}, g, ok);
        chk_word("queue word", model[q].pop_front(), g);
      end
    end
    pop(5'h00, d, ok, 1'b0);
    chk_bits("valid on empty queue", 4'h0, {3'h0, ok});
    chk_word("held output word", g, link.dout);
    $display("queue steering test done");
    // Modes: both narrow, wide in, wide out, both wide
    for (int m = 0; m < 4; m++) begin
      {out_wide_sel, in_wide_sel} = 2'(m);
      mreset();
      for (int k = 0; k < 2; k++) begin
        get_rand(d);
        push(5'h02, d);
        units.push_back(d[8:0]);
        if (m[0]) units.push_back(d[17:9]);
      end
      while (units.size() > 0) begin
        e = {9'h0, units.pop_front()};
        if (m[1]) e[17:9] = units.pop_front();
        pop(5'h02, g, ok);
        chk_word("matched word", e, g);
      end
    end
    $display("bus matching test done");
    for (int i = 0; i < 3; i++) begin
      get_rand(d);
      push(5'h01, d);
    end
    // Let the staged words reach the queue before clearing it
    cycles(10);
    pr_req = 1'b1;
    @(negedge clock);
    pr_req = 1'b0;
    cycles(10);
    pop(5'h01, g, ok, 1'b0);
    chk_bits("valid after partial reset", 4'h0, {3'h0, ok});
    get_rand(d);
    push(5'h01, d);
    pop(5'h01, g, ok);
    chk_word("word after partial reset", d, g);
    $display("partial reset test done");
    for (int nq = 1; nq <= QMAX; nq++) begin
      mreset();
      cfg_word = make_cfg(nq, BLK_W'(4 / nq));
      cfg_start = 1'b1;
      @(negedge clock);
      cfg_start = 1'b0;
      cycles(180);
      chk_bits("almost empty bus", 4'((1 << nq) - 1), link.almost_empty_status_bus);
      chk_bits("almost full bus", 4'h0, link.almost_full_status_bus);
      get_rand(d);
      push({3'h0, 2'(nq - 1)}, d);
      pop({3'h0, 2'(nq - 1)}, g, ok);
      chk_word("last queue word", d, g);
    end
    $display("serial setup test done");
    // Master reset held so the staging FIFO backs up, then drains into queue 0
    {mr_req, push_valid, push_queue} = {2'h3, 5'h00};
    for (int k = 0; k < 20; k++) begin
      get_rand(d);
      push_data = d;
      if (push_ready === 1'b1) fq.push_back(d);
      @(negedge clock);
    end
    {mr_req, push_valid} = 2'h0;
    chk_word("staging fill count", 18'(FIFO_DEPTH), 18'(fq.size()));
    chk_bits("staging ready when full", 4'h0, {3'h0, push_ready});
    while (fq.size() > 0) begin
      pop(5'h00, g, ok);
      chk_word("staging word", fq.pop_front(), g);
    end
    chk_bits("staging drained", 4'h1, {3'h0, push_ready});
    $display("staging buffer test done");
    finish_test();
  end
endmodule : testbench
